// ===== hdl/sclk_defines.svh
`ifndef SCLK_DEFINES_SVH
`define SCLK_DEFINES_SVH

// ============================================================
// Register byte offsets
`define SCLK_OFS_SYSCTL 4'h0
`define SCLK_OFS_PLLCTL 4'h4
`define SCLK_OFS_PRESC 4'h8
`define SCLK_OFS_STATUS 4'hC

// ============================================================
// Field layout
`define SCLK_SRC_LSB 0
`define SCLK_SRC_MSB 1
`define SCLK_PLL_MSB 21
`define SCLK_PRESC_MSB 9
`define SCLK_ST_PATH_LSB 0
`define SCLK_ST_SWITCH_BIT 2
`define SCLK_ST_LOCK_BIT 3
`define SCLK_ST_INC_LSB 16

// ============================================================
// Reset values
`define SCLK_RST_SYSCTL 32'h0000_0000
`define SCLK_RST_PLLCTL 32'h0000_0001
`define SCLK_RST_PRESC 32'h0000_0000

// ============================================================
// Oscillator model of the VCO, high band for code 01, low band otherwise
`define SCLK_INC_LOW 16'h0800
`define SCLK_INC_LOW_MIN 16'h0100
`define SCLK_INC_LOW_MAX 16'h1800
`define SCLK_INC_HIGH 16'h2000
`define SCLK_INC_HIGH_MIN 16'h1000
`define SCLK_INC_HIGH_MAX 16'h7000
`define SCLK_INC_STEP 16'h0001
`define SCLK_LOCK_TOL 8'h01

`endif

// ===== hdl/sclk_pkg.sv
package sclk_pkg;

  // Source select codes as written by software
  typedef enum logic [1:0] {
    SCLK_SEL_WAKEUP = 2'b00,
    SCLK_SEL_RSVD = 2'b01,
    SCLK_SEL_PLLPRE = 2'b10,
    SCLK_SEL_DIRECT = 2'b11
  } sclk_sel_t;

  // Internal clock path actually driving the output
  typedef enum logic [1:0] {
    SCLK_PATH_WAKEUP = 2'b00,
    SCLK_PATH_PRESC = 2'b01,
    SCLK_PATH_PLL = 2'b10,
    SCLK_PATH_DIRECT = 2'b11
  } sclk_path_t;

  // Source switch sequencer, three states
  typedef enum logic [1:0] {
    SCLK_SW_RUN = 2'b00,
    SCLK_SW_WAIT_OLD = 2'b01,
    SCLK_SW_WAIT_NEW = 2'b11
  } sclk_sw_t;

  // PLL control register layout
  typedef struct packed {
    logic [6:0] k2_div;
    logic [6:0] n_mul;
    logic [3:0] p_div;
    logic ref_sel;
    logic [1:0] band;
    logic bypass;
  } sclk_pll_cfg_t;

  // Wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } sclk_wb_req_t;

endpackage

// ===== hdl/sclk_top.sv
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "sclk_defines.svh"

// ============================================================
// Edge counting divider: output period is field+1 input periods
module sclk_div (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic src_i, // Sampled source clock level
  input wire logic [9:0] fld_i, // Divide field, factor is field+1
  output logic q_o // Divided clock level
);
  logic prev_q; // Previous source level
  logic [9:0] cnt_q; // Half periods seen since last toggle

  // Toggle after field+1 source edges of either polarity
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
      cnt_q <= 10'h000;
      q_o <= 1'b0;
    end else begin
      prev_q <= src_i;
      if (src_i != prev_q) begin
        if (cnt_q >= fld_i) begin
          cnt_q <= 10'h000;
          q_o <= ~q_o;
        end else begin
          cnt_q <= cnt_q + 10'h001;
        end
      end
    end
  end
endmodule

// ============================================================
// System clock source select and generation
module sclk_top (
  input wire logic clk_i, // System clock, 10 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire sclk_pkg::sclk_wb_req_t wb_req_i, // Wishbone request bundle
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic external_clock_pin_i, // External input clock level
  input wire logic osc_clk_i, // Oscillator clock level
  input wire logic internal_clk_i, // On-chip clock source level
  input wire logic wakeup_clk_i, // Low-frequency wakeup clock level
  output logic sys_clk_o // Generated system clock level
);
  import sclk_pkg::*;

  // ============================================================
  // Registers
  logic [31:0] system_clock_control_reg_q; // Source select
  logic [31:0] pll_control_reg_q; // PLL setup and bypass
  logic [31:0] presc_reg_q; // Prescaler divide field
  sclk_pll_cfg_t pll_cfg; // Decoded PLL setup
  logic [9:0] prescaler_divide_field; // Prescaler field
  logic wb_hit; // New bus access this cycle
  logic [31:0] wmask; // Byte lane mask
  logic [31:0] status_w; // Status word

  // Clock paths
  sclk_path_t req_path_q; // Path software asks for
  sclk_path_t act_path_q; // Path driving the output
  sclk_sw_t sw_q; // Switch sequencer state
  logic presc_clk; // Prescaler output
  logic pll_clk; // PLL output after K2
  logic src_act; // Level of active path
  logic src_req; // Level of requested path
  logic pll_on; // PLL loop running

  // PLL model
  logic [15:0] nco_acc_q; // Oscillator phase
  logic [15:0] inc_q; // Oscillator frequency word
  logic [15:0] inc_ctr; // Band centre
  logic [15:0] inc_min; // Band lower limit
  logic [15:0] inc_max; // Band upper limit
  logic ref_lvl; // Selected reference level
  logic ref_prev_q; // Previous reference level
  logic vco_prev_q; // Previous oscillator level
  logic [3:0] pcnt_q; // Reference edges in window
  logic [7:0] vcnt_q; // Oscillator edges in window
  logic locked_q; // Last window within tolerance
  logic ref_rise; // Reference rising edge
  logic vco_rise; // Oscillator rising edge
  logic win_end; // Comparison window closes
  logic [7:0] n_tgt; // Expected edges per window

  // ============================================================
  // Field decode and bus qualifiers
  // An access is taken only while ack is low, so a strobe that the
  // master still holds in the ack cycle is not taken twice
  assign pll_cfg = sclk_pll_cfg_t'(pll_control_reg_q[`SCLK_PLL_MSB:0]);
  assign prescaler_divide_field = presc_reg_q[`SCLK_PRESC_MSB:0];
  assign wb_hit = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  assign wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                  {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  assign status_w = {inc_q, 12'h000, locked_q, (sw_q != SCLK_SW_RUN), act_path_q};

  // ============================================================
  // Wishbone slave: one-cycle ack, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_req_i.we) begin
        case (wb_req_i.adr)
          `SCLK_OFS_SYSCTL: wb_dat_o <= system_clock_control_reg_q;
          `SCLK_OFS_PLLCTL: wb_dat_o <= pll_control_reg_q;
          `SCLK_OFS_PRESC: wb_dat_o <= presc_reg_q;
          `SCLK_OFS_STATUS: wb_dat_o <= status_w;
          default: wb_dat_o <= 32'h0000_0000; // Unmapped
        endcase
      end
    end
  end

  // Register writes with byte enables; unused bits stay zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_clock_control_reg_q <= `SCLK_RST_SYSCTL;
      pll_control_reg_q <= `SCLK_RST_PLLCTL;
      presc_reg_q <= `SCLK_RST_PRESC;
    end else if (wb_hit && wb_req_i.we) begin
      case (wb_req_i.adr)
        `SCLK_OFS_SYSCTL: system_clock_control_reg_q <= 32'h0000_0003 &
          ((system_clock_control_reg_q & ~wmask) | (wb_req_i.dat & wmask));
        `SCLK_OFS_PLLCTL: pll_control_reg_q <= 32'h003F_FFFF &
          ((pll_control_reg_q & ~wmask) | (wb_req_i.dat & wmask));
        `SCLK_OFS_PRESC: presc_reg_q <= 32'h0000_03FF &
          ((presc_reg_q & ~wmask) | (wb_req_i.dat & wmask));
        default: ; // Read-only or unmapped
      endcase
    end
  end

  // ============================================================
  // Requested path from select code and bypass bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_path_q <= SCLK_PATH_WAKEUP;
    end else begin
      case (sclk_sel_t'(system_clock_control_reg_q[`SCLK_SRC_MSB:`SCLK_SRC_LSB]))
        SCLK_SEL_WAKEUP: req_path_q <= SCLK_PATH_WAKEUP;
        SCLK_SEL_DIRECT: req_path_q <= SCLK_PATH_DIRECT;
        SCLK_SEL_PLLPRE: req_path_q <= pll_cfg.bypass ? SCLK_PATH_PRESC
                                                      : SCLK_PATH_PLL;
        default: req_path_q <= req_path_q;
      endcase
    end
  end

  // ============================================================
  // Prescaler: oscillator divided by field+1, up to 1024
  sclk_div u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_i(osc_clk_i),
    .fld_i(prescaler_divide_field),
    .q_o(presc_clk)
  );

  // ============================================================
  // PLL: frequency-locked oscillator model
  // The loop runs while the PLL path is wanted or still drives the
  // output; once neither holds it restarts from the band centre, so
  // a band change does not have to slew the whole way one step at a time
  assign pll_on = (req_path_q == SCLK_PATH_PLL) || (act_path_q == SCLK_PATH_PLL);
  assign ref_lvl = pll_cfg.ref_sel ? internal_clk_i : osc_clk_i;
  assign ref_rise = ref_lvl & ~ref_prev_q;
  assign vco_rise = nco_acc_q[15] & ~vco_prev_q;
  assign win_end = ref_rise && (pcnt_q == pll_cfg.p_div);
  assign n_tgt = {1'b0, pll_cfg.n_mul} + 8'h01;

  // Band centre and limits of the oscillator
  always_comb begin
    inc_ctr = `SCLK_INC_LOW;
    inc_min = `SCLK_INC_LOW_MIN;
    inc_max = `SCLK_INC_LOW_MAX;
    if (pll_cfg.band == 2'b01) begin
      inc_ctr = `SCLK_INC_HIGH;
      inc_min = `SCLK_INC_HIGH_MIN;
      inc_max = `SCLK_INC_HIGH_MAX;
    end
  end

  // Phase accumulator and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nco_acc_q <= 16'h0000;
      ref_prev_q <= 1'b0;
      vco_prev_q <= 1'b0;
    end else begin
      nco_acc_q <= pll_on ? nco_acc_q + inc_q : 16'h0000;
      ref_prev_q <= ref_lvl;
      vco_prev_q <= nco_acc_q[15];
    end
  end

  // Over P reference periods compare oscillator edges with N
  always_ff @(posedge clk_i) begin
    if (rst_i || !pll_on) begin
      pcnt_q <= 4'h0;
      vcnt_q <= 8'h00;
      inc_q <= rst_i ? `SCLK_INC_LOW : inc_ctr;
      locked_q <= 1'b0;
    end else begin
      if (win_end) begin
        pcnt_q <= 4'h0;
        vcnt_q <= vco_rise ? 8'h01 : 8'h00;
        if (vcnt_q < n_tgt && inc_q < inc_max) begin
          inc_q <= inc_q + `SCLK_INC_STEP;
        end else if (vcnt_q > n_tgt && inc_q > inc_min) begin
          inc_q <= inc_q - `SCLK_INC_STEP;
        end
        locked_q <= (vcnt_q + `SCLK_LOCK_TOL >= n_tgt) &&
                    (vcnt_q <= n_tgt + `SCLK_LOCK_TOL);
      end else begin
        if (ref_rise) begin
          pcnt_q <= pcnt_q + 4'h1;
        end
        if (vco_rise && vcnt_q != 8'hFF) begin
          vcnt_q <= vcnt_q + 8'h01;
        end
      end
    end
  end

  // Output divider K2 on the oscillator
  sclk_div u_k2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .src_i(nco_acc_q[15]),
    .fld_i({3'b000, pll_cfg.k2_div}),
    .q_o(pll_clk)
  );

  // ============================================================
  // Glitch-free switch: stop old path low, wait new path low
  // Both source levels are looked up every cycle; the sequencer
  // below decides which one reaches the output flop
  always_comb begin
    case (act_path_q)
      SCLK_PATH_WAKEUP: src_act = wakeup_clk_i;
      SCLK_PATH_PRESC: src_act = presc_clk;
      SCLK_PATH_PLL: src_act = pll_clk;
      default: src_act = external_clock_pin_i;
    endcase
    case (req_path_q)
      SCLK_PATH_WAKEUP: src_req = wakeup_clk_i;
      SCLK_PATH_PRESC: src_req = presc_clk;
      SCLK_PATH_PLL: src_req = pll_clk;
      default: src_req = external_clock_pin_i;
    endcase
  end

  // Switch sequencer and output flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_q <= SCLK_SW_RUN;
      act_path_q <= SCLK_PATH_WAKEUP;
      sys_clk_o <= 1'b0;
    end else begin
      case (sw_q)
        SCLK_SW_RUN: begin
          sys_clk_o <= src_act;
          if (req_path_q != act_path_q && !src_act) begin
            sw_q <= SCLK_SW_WAIT_OLD;
          end
        end
        SCLK_SW_WAIT_OLD: begin
          sys_clk_o <= 1'b0; // Hold low, old phase ended
          if (!src_req) begin
            sw_q <= SCLK_SW_WAIT_NEW;
          end
        end
        SCLK_SW_WAIT_NEW: begin
          sys_clk_o <= 1'b0;
          if (src_req) begin
            act_path_q <= req_path_q;
            sw_q <= SCLK_SW_RUN; // Join at new rising edge
          end
        end
        default: sw_q <= SCLK_SW_RUN;
      endcase
    end
  end
endmodule

// ===== verif/sclk_top_chk.sv
`timescale 1ns/1ns
// ============================================================
// Checker on the ports of the clock source selector
module sclk_top_chk
  import sclk_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire sclk_pkg::sclk_wb_req_t wb_req_i, // Bus request
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic external_clock_pin_i, // External clock
  input wire logic osc_clk_i, // Oscillator
  input wire logic internal_clk_i, // On-chip source
  input wire logic wakeup_clk_i, // Wakeup clock
  input wire logic sys_clk_o // Generated clock
);
  logic [1:0] eff_q; // Last valid select written
  logic [7:0] age_q; // Cycles since that write, saturating
  logic sel_wr; // Acked write to the select register
  logic rsvd_wr; // Same, carrying the reserved code
  logic settled; // Switch surely finished
  assign sel_wr = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & wb_ack_o
    & (wb_req_i.adr == 4'h0) & wb_req_i.sel[0];
  assign rsvd_wr = sel_wr & (wb_req_i.dat[1:0] == 2'h1);
  assign settled = age_q > 8'h64;
  // Track the requested source, reserved code changes nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eff_q <= 2'h0;
      age_q <= 8'h00;
    end else if (sel_wr && !rsvd_wr) begin
      eff_q <= wb_req_i.dat[1:0];
      age_q <= 8'h00;
    end else if (age_q != 8'hFF) begin
      age_q <= age_q + 8'h01;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ============================================================
  // Assertions
  a_direct_follow: assert property (eff_q == 2'h3 && settled |-> sys_clk_o == $past(external_clock_pin_i))
    else $error("output does not follow external pin");
  a_wakeup_follow: assert property (eff_q == 2'h0 && settled |-> sys_clk_o == $past(wakeup_clk_i))
    else $error("output does not follow wakeup clock");
  a_rsvd_keep: assert property (rsvd_wr && eff_q == 2'h3 && settled |=> (sys_clk_o == $past(external_clock_pin_i))[*4])
    else $error("reserved code changed the source");
  a_high_phase: assert property ($rose(sys_clk_o) |=> sys_clk_o)
    else $error("high phase too short");
  a_low_phase: assert property ($fell(sys_clk_o) |=> !sys_clk_o)
    else $error("low phase too short");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_reset_quiet: assert property ($fell(rst_i) |-> !sys_clk_o && !wb_ack_o && wb_dat_o == 32'h0)
    else $error("outputs not cleared by reset");
endmodule

bind sclk_top sclk_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .external_clock_pin_i(external_clock_pin_i),
  .osc_clk_i(osc_clk_i), .internal_clk_i(internal_clk_i), .wakeup_clk_i(wakeup_clk_i),
  .sys_clk_o(sys_clk_o));

// ===== verif/sclk_top_tb.sv
`timescale 1ns/1ns
// ============================================================
// Self-checking bench for the clock source selector
module sclk_top_tb;
  import sclk_pkg::*;
  logic clk_i = 1'b0; // Bench clock
  logic rst_i = 1'b1; // Reset
  sclk_wb_req_t req = '0; // Bus request
  logic [31:0] rdat; // Read data
  logic ack; // Acknowledge
  logic sys_clk; // Generated clock
  logic ext = 1'b0; // External pin
  logic osc = 1'b0; // Oscillator
  logic intc = 1'b0; // On-chip source
  logic wku = 1'b0; // Wakeup source
  logic [31:0] d; // Last read value
  int ph = 0; // Cycle counter
  int errors = 0; // Mismatches
  int n_tests = 0; // Comparisons
  always #50 clk_i = ~clk_i;
  sclk_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(rdat),
    .wb_ack_o(ack), .external_clock_pin_i(ext), .osc_clk_i(osc), .internal_clk_i(intc),
    .wakeup_clk_i(wku), .sys_clk_o(sys_clk));
  // ============================================================
  // Sources with half periods 3, 8, 16 and 5 cycles; hang limit
  always @(posedge clk_i) begin
    ph <= ph + 1;
    ext <= (((ph + 1) / 3) % 2) == 1;
    osc <= (((ph + 1) / 8) % 2) == 1;
    intc <= (((ph + 1) / 16) % 2) == 1;
    wku <= (((ph + 1) / 5) % 2) == 1;
    if (ph == 60000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  // ============================================================
  // Tasks
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  // One classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: v};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    d = rdat;
    req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    check(nm, e, d);
  endtask
  // Count output rising edges after a settle time, one edge of slack
  task automatic meas(input int w, input int e, input string nm);
    int c;
    logic p;
    c = 0;
    repeat (300) @(posedge clk_i);
    p = sys_clk;
    repeat (w) begin
      @(posedge clk_i);
      if (sys_clk === 1'b1 && p === 1'b0) c++;
      p = sys_clk;
    end
    n_tests++;
    if (c < e - 1 || c > e + 1) begin
      errors++;
      $display("unexpected %s edges: expected %0d seen %0d", nm, e, c);
    end
    $display("test %s done", nm);
  endtask
  // ============================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 32'h0, "select reset");
    rd(4'h4, 32'h1, "pll reset");
    rd(4'h8, 32'h0, "presc reset");
    wb(1'b1, 4'h2, 32'hFFFF_FFFF);
    rd(4'h2, 32'h0, "unmapped");
    meas(320, 32, "wakeup");
    wb(1'b1, 4'h0, 32'hFFFF_FFFF);
    rd(4'h0, 32'h3, "select");
    meas(320, 53, "direct");
    wb(1'b0, 4'hC, 32'h0);
    check("path", 32'h3, d & 32'h3);
    wb(1'b1, 4'h0, 32'h1);
    meas(320, 53, "reserved");
    wb(1'b1, 4'h0, 32'h2);
    meas(320, 20, "divide one");
    wb(1'b1, 4'h8, 32'h3);
    meas(320, 5, "divide four");
    wb(1'b1, 4'h4, 32'h8);
    meas(320, 10, "pll low");
    wb(1'b0, 4'hC, 32'h0);
    check("lock", 32'hA, d & 32'hF);
    // Set the new band with bypass first, so the loop restarts from its centre
    wb(1'b1, 4'h4, 32'h8313);
    meas(320, 5, "pll bypass");
    wb(1'b1, 4'h4, 32'h8312);
    meas(320, 20, "pll high");
    wb(1'b0, 4'hC, 32'h0);
    check("lock high", 32'hA, d & 32'hF);
    wb(1'b1, 4'h4, 32'h1);
    wb(1'b1, 4'h8, 32'hFFFF_FFFF);
    rd(4'h8, 32'h3FF, "presc max");
    meas(40000, 2, "divide max");
    end_sim();
  end
endmodule
